// ### verilog/pcr_regs.sv
// pcr_regs: pad configuration registers, clock-generator registers and soft reset control.
// assumes one register access per cycle from the control port; reads answer a cycle later.
`timescale 1ns/100ps
module pcr_regs
   import pcr_pkg::*;
#(
   parameter int SERIAL_PADS = PCR_SERIAL_PADS
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [PCR_ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [PCR_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [PCR_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // control port mode
   input wire logic i_spi_select,
   output logic o_spi_mode,
   // soft reset to the rest of the device
   output logic o_soft_reset_active,
   // pad configuration
   output logic [SERIAL_PADS-1:0] o_serial_pad_pulldown_en,
   output logic [2*SERIAL_PADS-1:0] o_serial_pad_edge_rate,
   output logic [2*SERIAL_PADS-1:0] o_serial_pad_strength,
   output logic o_mpa_pullup_en,
   output logic [1:0] o_mpa_edge_rate,
   output logic [1:0] o_mpa_strength,
   output logic o_mpb_pullup_en,
   output logic [1:0] o_mpb_edge_rate,
   output logic [1:0] o_mpb_strength,
   // clock-generator registers, first at the low end
   output logic [PCR_CLKGEN_REGS*PCR_DATA_W-1:0] o_clkgen_cfg
);
   // the decode and field slicing serve exactly eight serial pads
   if (SERIAL_PADS != PCR_SERIAL_PADS) begin : g_bad_pads
      $error("pcr_regs: serial pad count must be 8");
   end

   logic restart_n;
   logic soft_clr;
   logic [4:0] serial_cfg [SERIAL_PADS];
   logic [4:0] mpa_cfg;
   logic [4:0] mpb_cfg;
   logic [PCR_DATA_W-1:0] clkgen [PCR_CLKGEN_REGS];
   logic [15:0] serial_off;
   logic [15:0] clkgen_off;
   logic serial_hit;
   logic clkgen_hit;
   logic mpa_hit;
   logic mpb_hit;
   logic restart_hit;
   logic [2:0] serial_idx;
   logic [2:0] clkgen_idx;
   logic [4:0] live_wdata;
   logic [PCR_DATA_W-1:0] next_rdata;

   assign soft_clr = ~restart_n;
   assign o_soft_reset_active = soft_clr;

   // address decode
   assign serial_off = i_reg_addr - PCR_SERIAL_PAD0_ADDR;
   assign clkgen_off = i_reg_addr - PCR_CLKGEN_FIRST_ADDR;
   assign serial_hit = (i_reg_addr >= PCR_SERIAL_PAD0_ADDR) && (serial_off < 16'(SERIAL_PADS));
   assign serial_idx = serial_off[2:0];
   assign mpa_hit = (i_reg_addr == PCR_MPA_ADDR);
   assign mpb_hit = (i_reg_addr == PCR_MPB_ADDR);
   assign restart_hit = (i_reg_addr == PCR_RESTART_ADDR);
   assign clkgen_hit = (i_reg_addr >= PCR_CLKGEN_FIRST_ADDR) &&
                       (i_reg_addr <= PCR_CLKGEN_LAST_ADDR);
   assign clkgen_idx = clkgen_off[2:0];
   assign live_wdata = i_reg_wdata[PCR_FIELD_W-1:0];

   genvar g;
   generate
      for (g = 0; g < SERIAL_PADS; g++) begin : g_serial
         pcr_pad_reg #(
            .RESET_VAL(PCR_SERIAL_RST)
         ) u_pad (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_soft_clr(soft_clr),
            .i_wr(i_reg_wr && serial_hit && (serial_idx == 3'(g))),
            .i_wdata(live_wdata),
            .o_cfg(serial_cfg[g])
         );
         assign o_serial_pad_pulldown_en[g] = serial_cfg[g][PCR_PULL_BIT];
         assign o_serial_pad_edge_rate[2*g +: 2] = serial_cfg[g][PCR_RATE_LSB +: 2];
         assign o_serial_pad_strength[2*g +: 2] = serial_cfg[g][PCR_STRENGTH_LSB +: 2];
      end
   endgenerate

   // pullup pads, reset 0x08 live bits
   pcr_pad_reg #(
      .RESET_VAL(PCR_MP_RST)
   ) u_mpa (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_soft_clr(soft_clr),
      .i_wr(i_reg_wr && mpa_hit),
      .i_wdata(live_wdata),
      .o_cfg(mpa_cfg)
   );
   pcr_pad_reg #(
      .RESET_VAL(PCR_MP_RST)
   ) u_mpb (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_soft_clr(soft_clr),
      .i_wr(i_reg_wr && mpb_hit),
      .i_wdata(live_wdata),
      .o_cfg(mpb_cfg)
   );
   assign o_mpa_pullup_en = mpa_cfg[PCR_PULL_BIT];
   assign o_mpa_edge_rate = mpa_cfg[PCR_RATE_LSB +: 2];
   assign o_mpa_strength = mpa_cfg[PCR_STRENGTH_LSB +: 2];
   assign o_mpb_pullup_en = mpb_cfg[PCR_PULL_BIT];
   assign o_mpb_edge_rate = mpb_cfg[PCR_RATE_LSB +: 2];
   assign o_mpb_strength = mpb_cfg[PCR_STRENGTH_LSB +: 2];

   // the control bit itself is spared by soft reset, else it could never be released
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) restart_n <= PCR_RESTART_RST;
      else if (i_reg_wr && restart_hit) restart_n <= i_reg_wdata[0];
   end

   generate
      for (g = 0; g < PCR_CLKGEN_REGS; g++) begin : g_clkgen
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) clkgen[g] <= PCR_CLKGEN_RST;
            else if (i_reg_wr && clkgen_hit && (clkgen_idx == 3'(g))) clkgen[g] <= i_reg_wdata;
         end
         assign o_clkgen_cfg[g*PCR_DATA_W +: PCR_DATA_W] = clkgen[g];
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) o_spi_mode <= 1'b0;
      else if (i_spi_select) o_spi_mode <= 1'b1;
   end

   assign next_rdata = serial_hit ? {11'h000, serial_cfg[serial_idx]} :
                       mpa_hit ? {11'h000, mpa_cfg} :
                       mpb_hit ? {11'h000, mpb_cfg} :
                       restart_hit ? {15'h0000, restart_n} :
                       clkgen_hit ? clkgen[clkgen_idx] : 16'h0000;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 16'h0000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) o_reg_rdata <= next_rdata;
      end
   end
endmodule : pcr_regs

// ### verilog/pcr_pkg.sv
// pcr_pkg: offsets, field layout and reset values of the pad config and soft reset block.
// assumes a 16-bit register port driven by the device's slave control ports.
// What this block does
// - eight serial data pad registers, reset 0x0018
// - serial pad pulldown, edge rate, strength fields
// - first multipurpose pad register with pullup
// - second multipurpose pad register, same layout
// - soft reset bit 0, active low
// - soft reset defaults the pad registers only
// - control port and clock-generator writes stay alive
// - spi slave mode survives soft reset
package pcr_pkg;
   localparam int PCR_DATA_W = 16;
   localparam int PCR_ADDR_W = 16;
   localparam int PCR_SERIAL_PADS = 8;
   localparam int PCR_CLKGEN_REGS = 7;
   localparam int PCR_FIELD_W = 5;
   localparam logic [15:0] PCR_SERIAL_PAD0_ADDR = 16'hf7b0;
   localparam logic [15:0] PCR_MPA_ADDR = 16'hf7b8;
   localparam logic [15:0] PCR_MPB_ADDR = 16'hf7b9;
   localparam logic [15:0] PCR_RESTART_ADDR = 16'hf890;
   localparam logic [15:0] PCR_CLKGEN_FIRST_ADDR = 16'hf000;
   localparam logic [15:0] PCR_CLKGEN_LAST_ADDR = 16'hf006;
   localparam int PCR_PULL_BIT = 4;
   localparam int PCR_RATE_LSB = 2;
   localparam int PCR_STRENGTH_LSB = 0;
   localparam logic [4:0] PCR_SERIAL_RST = 5'h18;
   localparam logic [4:0] PCR_MP_RST = 5'h08;
   localparam logic PCR_RESTART_RST = 1'b1;
   localparam logic [15:0] PCR_CLKGEN_RST = 16'h0000;
endpackage : pcr_pkg

// ### verilog/pcr_pad_reg.sv
// pcr_pad_reg: one pad configuration register, five live bits.
// assumes the parent decodes the address and supplies the soft clear.
`timescale 1ns/100ps
module pcr_pad_reg
   import pcr_pkg::*;
#(
   parameter logic [4:0] RESET_VAL = PCR_SERIAL_RST
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_soft_clr,
   input wire logic i_wr,
   input wire logic [4:0] i_wdata,
   // state
   output logic [4:0] o_cfg
);
   logic [4:0] next_cfg;

   assign next_cfg = i_soft_clr ? RESET_VAL : (i_wr ? i_wdata : o_cfg);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) o_cfg <= RESET_VAL;
      else o_cfg <= next_cfg;
   end
endmodule : pcr_pad_reg

// ### sim/pcr_regs_chk.sv
// pcr_regs_chk: port-level assertions for the pad config and soft reset registers.
// assumes it is bound into pcr_regs and sees its ports under their own names.
`timescale 1ns/100ps
module pcr_regs_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_rd,
   input wire logic o_reg_rvalid,
   // mode and soft reset
   input wire logic i_spi_select,
   input wire logic o_spi_mode,
   input wire logic o_soft_reset_active,
   // state
   input wire logic [7:0] o_serial_pad_pulldown_en,
   input wire logic [1:0] o_mpa_edge_rate,
   input wire logic [111:0] o_clkgen_cfg
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_rv; i_reg_rd |=> o_reg_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read not answered");
   property p_norv; !i_reg_rd |=> !o_reg_rvalid; endproperty
   a_norv: assert property (p_norv) else $error("stray read valid");
   property p_sr; i_reg_wr && i_reg_addr == 16'hf890 |=>
      o_soft_reset_active == !$past(i_reg_wdata[0]); endproperty
   a_sr: assert property (p_sr) else $error("soft reset bit polarity");
   property p_pad; o_soft_reset_active |=> o_serial_pad_pulldown_en == 8'hff; endproperty
   a_pad: assert property (p_pad) else $error("serial pad not default");
   property p_mp; o_soft_reset_active |=> o_mpa_edge_rate == 2'b10; endproperty
   a_mp: assert property (p_mp) else $error("mp pad not default");
   property p_ck; i_reg_wr && i_reg_addr == 16'hf000 |=>
      o_clkgen_cfg[15:0] == $past(i_reg_wdata); endproperty
   a_ck: assert property (p_ck) else $error("clock-generator write lost");
   property p_ckh; !i_reg_wr |=> $stable(o_clkgen_cfg); endproperty
   a_ckh: assert property (p_ckh) else $error("clock-generator changed");
   property p_spi; i_spi_select || o_spi_mode |=> o_spi_mode; endproperty
   a_spi: assert property (p_spi) else $error("spi mode lost");
endmodule : pcr_regs_chk

// ### sim/pcr_regs_bench.sv
// pcr_regs_bench: register reads, soft reset and mode checks for pcr_regs.
// assumes the default parameters of pcr_regs; one access every other cycle.
`timescale 1ns/100ps
module pcr_regs_bench;
   logic i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_spi_select = 0;
   logic [15:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
   logic o_reg_rvalid, o_spi_mode, o_soft_reset_active, o_mpa_pullup_en, o_mpb_pullup_en;
   logic [7:0] o_serial_pad_pulldown_en;
   logic [15:0] o_serial_pad_edge_rate, o_serial_pad_strength;
   logic [1:0] o_mpa_edge_rate, o_mpa_strength, o_mpb_edge_rate, o_mpb_strength;
   logic [111:0] o_clkgen_cfg;
   int err_count = 0, cmp_count = 0;
   logic [15:0] ra [7] = '{16'hf7b0, 16'hf7b7, 16'hf7b8, 16'hf7b9, 16'hf890, 16'hf006, 16'hf7ba};
   logic [15:0] re [7] = '{16'h0018, 16'h0018, 16'h0008, 16'h0008, 16'h0001, 16'h0000, 16'h0000};
   pcr_regs DUT (.*);
   always #12.5 i_clk = ~i_clk;
   task summarize;
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 0;
      #1;
   endtask : wr
   task rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_reg_rd <= 1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 0;
      #1;
      chk(o_reg_rvalid, 1);
      chk(o_reg_rdata, exp);
   endtask : rd
   initial begin
      #100us;
      err_count++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 0;
      // reset values, unmapped reads zero
      for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
      wr(16'hf7b3, 16'hffff);
      rd(16'hf7b3, 16'h001f);
      chk(o_serial_pad_edge_rate[7:6], 2'b11);
      chk(o_serial_pad_strength[7:6], 2'b11);
      chk(o_serial_pad_pulldown_en, 8'hff);
      chk(o_serial_pad_strength[5:4], 2'b00);
      wr(16'hf7b9, 16'hffff);
      chk(o_mpb_pullup_en, 1);
      chk(o_mpb_edge_rate, 2'b11);
      chk(o_mpb_strength, 2'b11);
      chk(o_mpa_pullup_en, 0);
      chk(o_mpa_edge_rate, 2'b10);
      chk(o_mpa_strength, 2'b00);
      wr(16'hf890, 16'h0000);
      chk(o_soft_reset_active, 1);
      rd(16'hf7b3, 16'h0018);
      rd(16'hf7b9, 16'h0008);
      wr(16'hf7b3, 16'h0003);
      rd(16'hf7b3, 16'h0018);
      wr(16'hf003, 16'habcd);
      rd(16'hf003, 16'habcd);
      chk(o_clkgen_cfg[63:48], 16'habcd);
      wr(16'hf000, 16'h1234);
      chk(o_clkgen_cfg[15:0], 16'h1234);
      chk(o_mpb_edge_rate, 2'b10);
      @(posedge i_clk);
      i_spi_select <= 1;
      @(posedge i_clk);
      i_spi_select <= 0;
      wr(16'hf890, 16'hffff);
      chk(o_soft_reset_active, 0);
      chk(o_spi_mode, 1);
      rd(16'hf890, 16'h0001);
      rd(16'hf003, 16'habcd);
      chk(o_clkgen_cfg[15:0], 16'h1234);
      // only the hardware reset returns the port to i2c
      @(posedge i_clk);
      i_sys_rst <= 1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 0;
      @(posedge i_clk);
      #1;
      chk(o_spi_mode, 0);
      chk(o_clkgen_cfg[63:48], 16'h0000);
      rd(16'hf7b3, 16'h0018);
      summarize();
   end
endmodule : pcr_regs_bench
bind pcr_regs pcr_regs_chk u_chk (.*);
